// *** design/rtw_ramp_lock.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Each channel keeps the sequence timer value seen when it meets its capture condition.
// - In a power-on or sleep-exit sequence (code 01) capture happens on the low-fine rising crossing.
// - In a power-off or sleep-entry sequence (code 10) capture happens on the 200mV falling crossing.
// - The sequence timer advances once every 50 us.
// - Each timestamp is split into a read-only high byte at the even index and a low byte.
// - Bit 0 of the bank register picks bank 0 or 1, resets to zero, and bits 7:1 read zero.
// - A group is locked only when its bit is set in both lock registers.
// - Both lock registers reset to zero and a host write can never clear a set bit.
// - Lock bits clear only on power-up, soft reset, or self-test at sequence 2 exit when enabled.
// - Bit 5 locks the control working group against host writes.
// - Bit 4 locks the sequence working group against host writes.
// - Bit 3 locks the configuration group against host writes.
// - Bit 2 locks the interrupt enable group against host writes.
// - Bit 1 locks the whole monitor group, and the monitor registers of channels chosen in the channel select register.
// - Bit 0 locks the sequence group, and bits 7:6 of the lock registers read zero.
// - The channel select register holds one bit per channel in 5:0, resetting to ones.
module rtw_ramp_lock (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [9:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [1:0]           power_state_input,
   input  wire logic [1:0]           sleep_state_input,
   input  wire logic [1:0]           undervolt_low_fine_above,
   input  wire logic [1:0]           off_level_above,
   input  wire logic                 selftest_seq2_exit_done,
   output logic                      bank_select_out,
   output logic [5:0]                group_write_block,
   output logic [5:0]                channel_watch_block,
   output logic                      supervisor_soft_reset
);
   import rtw_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [8:0]     sync1_r;
   logic [8:0]     sync2_r;
   logic [3:0]     lvl_prev_r;
   logic [1:0]     pwr_code;
   logic [1:0]     slp_code;
   logic [1:0]     pwr_prev_r;
   logic [1:0]     slp_prev_r;
   logic [1:0]     uv_above;
   logic [1:0]     off_above;
   logic [1:0]     uv_rise;
   logic [1:0]     off_fall;
   logic           selftest_done;

   // Every pin passes two flops; edges are taken from the second stage only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r    <= '0;
         sync2_r    <= '0;
         lvl_prev_r <= '0;
         pwr_prev_r <= '0;
         slp_prev_r <= '0;
      end else begin
         sync1_r    <= {selftest_seq2_exit_done, off_level_above, undervolt_low_fine_above,
                        sleep_state_input, power_state_input};
         sync2_r    <= sync1_r;
         lvl_prev_r <= sync2_r[7:4];
         pwr_prev_r <= sync2_r[1:0];
         slp_prev_r <= sync2_r[3:2];
      end
   end

   assign pwr_code      = sync2_r[1:0];
   assign slp_code      = sync2_r[3:2];
   assign uv_above      = sync2_r[5:4];
   assign off_above     = sync2_r[7:6];
   assign selftest_done = sync2_r[8];
   assign uv_rise       = uv_above & ~lvl_prev_r[1:0];
   assign off_fall      = ~off_above & lvl_prev_r[3:2];

   // ----------------------------------------------------------------
   // Sequence timer
   // ----------------------------------------------------------------
   rtw_seq_state_t seq_r;
   rtw_seq_state_t seq_nxt;
   logic [8:0]     presc_r;
   logic [15:0]    timer_r;
   logic [1:0]     captured_r;
   logic           start_on;
   logic           start_off;
   logic           tick;
   logic [1:0]     cap_hit;

   // A sequence begins when either control input newly shows an active code.
   assign start_on  = (pwr_code == SEQ_CODE_ON && pwr_prev_r != SEQ_CODE_ON)
                    || (slp_code == SEQ_CODE_ON && slp_prev_r != SEQ_CODE_ON);
   assign start_off = (pwr_code == SEQ_CODE_OFF && pwr_prev_r != SEQ_CODE_OFF)
                    || (slp_code == SEQ_CODE_OFF && slp_prev_r != SEQ_CODE_OFF);
   assign tick      = (seq_r != RTW_SEQ_IDLE) && (presc_r == TICK_LAST);
   assign cap_hit   = (seq_r == RTW_SEQ_ON)  ? (uv_rise  & ~captured_r) :
                      (seq_r == RTW_SEQ_OFF) ? (off_fall & ~captured_r) :
                      2'h0;

   // A sequence ends once both channels hold a stamp; a new start restarts it.
   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         RTW_SEQ_IDLE: begin
            if (start_on) seq_nxt = RTW_SEQ_ON;
            else if (start_off) seq_nxt = RTW_SEQ_OFF;
         end
         RTW_SEQ_ON, RTW_SEQ_OFF: begin
            if (start_on) seq_nxt = RTW_SEQ_ON;
            else if (start_off) seq_nxt = RTW_SEQ_OFF;
            else if ((captured_r | cap_hit) == 2'h3) seq_nxt = RTW_SEQ_IDLE;
         end
         default: seq_nxt = RTW_SEQ_IDLE;
      endcase
   end

   // The timer saturates rather than wrapping, so a stuck rail never aliases to an early stamp.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r      <= RTW_SEQ_IDLE;
         presc_r    <= '0;
         timer_r    <= '0;
         captured_r <= '0;
      end else begin
         seq_r <= seq_nxt;
         if (start_on || start_off) begin
            presc_r    <= '0;
            timer_r    <= '0;
            captured_r <= '0;
         end else begin
            presc_r    <= tick ? 9'h000 : (seq_r != RTW_SEQ_IDLE ? presc_r + 9'h001 : presc_r);
            timer_r    <= (tick && timer_r != 16'hffff) ? timer_r + 16'h0001 : timer_r;
            captured_r <= captured_r | cap_hit;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timestamp store
   // ----------------------------------------------------------------
   logic [15:0]    stamp_r [2];

   // Each channel keeps the timer value of its own crossing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_r[0] <= STAMP_RST;
         stamp_r[1] <= STAMP_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_hit[i]) stamp_r[i] <= timer_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic [7:0]     idx;
   logic           setup_ph;
   logic           wr_en;
   logic           wr_lane;
   logic           bank0;
   logic           hit_stamp;
   logic           hit_common;
   logic           mapped;
   logic           wr_bank;
   logic           wr_lock1;
   logic           wr_lock2;
   logic           wr_chsel;
   logic           wr_aux;
   logic           bank_r;

   // Zero wait states: every access phase completes at its first edge.
   assign idx        = rtw_index(paddr);
   assign pready     = 1'b1;
   assign setup_ph   = psel && !penable;
   assign wr_en      = psel && penable && pwrite;
   assign wr_lane    = pstrb[0];
   assign bank0      = !bank_r;
   assign hit_stamp  = bank0 && (idx >= IDX_CH7_HIGH) && (idx <= IDX_CH8_LOW);
   assign hit_common = (idx == IDX_BANK_SEL) || (idx == IDX_LOCK_ONE) || (idx == IDX_LOCK_TWO)
                     || (idx == IDX_CH_SELECT) || (idx == IDX_AUX_CTRL);
   assign mapped     = hit_stamp || hit_common;
   assign wr_bank    = wr_en && wr_lane && idx == IDX_BANK_SEL;
   assign wr_lock1   = wr_en && wr_lane && idx == IDX_LOCK_ONE;
   assign wr_lock2   = wr_en && wr_lane && idx == IDX_LOCK_TWO;
   assign wr_chsel   = wr_en && wr_lane && idx == IDX_CH_SELECT;
   assign wr_aux     = wr_en && wr_lane && idx == IDX_AUX_CTRL;

   // ----------------------------------------------------------------
   // Bank select and lock registers
   // ----------------------------------------------------------------
   logic [5:0]     lock1_r;
   logic [5:0]     lock2_r;
   logic [5:0]     chsel_r;
   logic           selftest_en_r;
   logic           soft_rst_r;
   logic           lock_clear;
   logic [5:0]     both_locked;

   assign both_locked = lock1_r & lock2_r;
   assign lock_clear  = soft_rst_r || (selftest_done && selftest_en_r);

   // Lock registers only ever gain bits from the host; a host set in the clear cycle survives.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_r  <= BANK_RST;
         lock1_r <= LOCK_RST;
         lock2_r <= LOCK_RST;
      end else begin
         if (wr_bank) bank_r <= pwdata[0];
         lock1_r <= (lock_clear ? LOCK_RST : lock1_r) | (wr_lock1 ? pwdata[5:0] : 6'h00);
         lock2_r <= (lock_clear ? LOCK_RST : lock2_r) | (wr_lock2 ? pwdata[5:0] : 6'h00);
      end
   end

   // The channel select belongs to the monitor group; the self-test enable to configuration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chsel_r       <= CH_SELECT_RST;
         selftest_en_r <= SELFTEST_RST;
         soft_rst_r    <= 1'b0;
      end else begin
         if (wr_chsel && !both_locked[LOCK_RAIL_WATCH_BIT]) chsel_r <= pwdata[5:0];
         if (wr_aux && !both_locked[LOCK_CFG_BIT])
            selftest_en_r <= pwdata[AUX_SELFTEST_BIT];
         soft_rst_r <= wr_aux && !both_locked[LOCK_CTRL_WORK_BIT]
                       && pwdata[AUX_SOFT_RST_BIT];
      end
   end

   // Gates for registers held elsewhere in the supervisor, one per group.
   assign group_write_block[LOCK_CTRL_WORK_BIT]  = both_locked[LOCK_CTRL_WORK_BIT];
   assign group_write_block[LOCK_RAMP_WORK_BIT]  = both_locked[LOCK_RAMP_WORK_BIT];
   assign group_write_block[LOCK_CFG_BIT]        = both_locked[LOCK_CFG_BIT];
   assign group_write_block[LOCK_IRQ_MASK_BIT]   = both_locked[LOCK_IRQ_MASK_BIT];
   assign group_write_block[LOCK_RAIL_WATCH_BIT] = both_locked[LOCK_RAIL_WATCH_BIT];
   assign group_write_block[LOCK_RAMP_ORDER_BIT] = both_locked[LOCK_RAMP_ORDER_BIT];
   assign channel_watch_block = chsel_r & {6{both_locked[LOCK_RAIL_WATCH_BIT]}};
   assign bank_select_out     = bank_r;
   assign supervisor_soft_reset = soft_rst_r;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0]    rd_word;
   logic [31:0]    prdata_r;
   logic           err_r;

   // Reserved bits read zero; locked registers still read back their contents.
   always_comb begin
      rd_word = 32'h0000_0000;
      case (idx)
         IDX_CH7_HIGH:  rd_word = rtw_byte(stamp_r[0][15:8]);
         IDX_CH7_LOW:   rd_word = rtw_byte(stamp_r[0][7:0]);
         IDX_CH8_HIGH:  rd_word = rtw_byte(stamp_r[1][15:8]);
         IDX_CH8_LOW:   rd_word = rtw_byte(stamp_r[1][7:0]);
         IDX_BANK_SEL:  rd_word = rtw_byte({7'h00, bank_r});
         IDX_LOCK_ONE:  rd_word = rtw_byte({2'h0, lock1_r});
         IDX_LOCK_TWO:  rd_word = rtw_byte({2'h0, lock2_r});
         IDX_CH_SELECT: rd_word = rtw_byte({2'h0, chsel_r});
         IDX_AUX_CTRL:  rd_word = rtw_byte({6'h00, selftest_en_r, 1'b0});
         default:       rd_word = 32'h0000_0000;
      endcase
      if (!mapped) rd_word = 32'h0000_0000;
   end

   // Read data and error are captured in setup so they leave a flop in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         err_r    <= 1'b0;
      end else if (setup_ph) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
         err_r    <= !mapped;
      end
   end

   assign prdata  = prdata_r;
   assign pslverr = err_r && psel && penable;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_lock_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !lock_clear |=> ((lock1_r & $past(lock1_r)) == $past(lock1_r))
                   && ((lock2_r & $past(lock2_r)) == $past(lock2_r)))
      else $error("lock bit dropped without a clear event");

   a_soft_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_aux && pwdata[AUX_SOFT_RST_BIT] && !both_locked[LOCK_CTRL_WORK_BIT]
       && !wr_lock1 && !wr_lock2) ##1 (!wr_lock1 && !wr_lock2)
      |=> (lock1_r == LOCK_RST) && (lock2_r == LOCK_RST))
      else $error("soft reset did not clear the lock registers");

   a_cfg_write_block: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_aux && both_locked[LOCK_CFG_BIT]) |=> $stable(selftest_en_r))
      else $error("locked configuration bit changed");

   a_chsel_write_block: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_chsel && both_locked[LOCK_RAIL_WATCH_BIT]) |=> $stable(chsel_r))
      else $error("locked channel select changed");

   a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !start_on && !start_off) ##1 (!start_on && !start_off)[*8] |-> !tick)
      else $error("timestamp tick came too soon");

   a_capture_on: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_r == RTW_SEQ_ON && uv_rise[0] && !captured_r[0])
      |=> stamp_r[0] == $past(timer_r))
      else $error("power-on stamp not taken on the low-fine crossing");

   a_capture_off: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_r == RTW_SEQ_OFF && off_fall[1] && !captured_r[1])
      |=> stamp_r[1] == $past(timer_r))
      else $error("power-off stamp not taken on the off crossing");

   a_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_bank |=> bank_select_out == $past(pwdata[0]))
      else $error("bank select did not follow the write");

   a_stamp_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && bank0 && idx == IDX_CH8_HIGH)
      |=> prdata == {24'h00_0000, $past(stamp_r[1][15:8])})
      else $error("high byte read mismatch");

   a_lock_both: assert property (@(posedge pclk) disable iff (!presetn)
      (lock1_r[LOCK_IRQ_MASK_BIT] != lock2_r[LOCK_IRQ_MASK_BIT])
      |-> !group_write_block[LOCK_IRQ_MASK_BIT])
      else $error("group locked with only one register set");

   // Stamps change only through a capture, which is what keeps them read-only to the host.
   a_stamp_read_only: assert property (@(posedge pclk) disable iff (!presetn)
      (cap_hit == 2'h0) |=> $stable(stamp_r[0]) && $stable(stamp_r[1]))
      else $error("timestamp changed without a capture");

   a_selftest_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (selftest_done && selftest_en_r && !wr_lock1 && !wr_lock2)
      |=> (lock1_r == LOCK_RST) && (lock2_r == LOCK_RST))
      else $error("self-test exit did not clear the lock registers");

   a_soft_reset_block: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_aux && both_locked[LOCK_CTRL_WORK_BIT]) |=> !supervisor_soft_reset)
      else $error("soft reset pulsed while the control group was locked");

   a_lock_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && (idx == IDX_LOCK_ONE || idx == IDX_LOCK_TWO))
      |=> prdata[31:6] == 26'h000_0000)
      else $error("reserved lock bits read back set");

   a_capture_ch7_off: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_r == RTW_SEQ_OFF && off_fall[0] && !captured_r[0])
      |=> stamp_r[0] == $past(timer_r))
      else $error("power-off stamp of the first channel missed");

   a_capture_ch8_on: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_r == RTW_SEQ_ON && uv_rise[1] && !captured_r[1])
      |=> stamp_r[1] == $past(timer_r))
      else $error("power-on stamp of the second channel missed");

endmodule // rtw_ramp_lock

// *** design/rtw_pkg.sv ***
package rtw_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index).
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CH7_HIGH  = 8'h9c;
   localparam logic [7:0] IDX_CH7_LOW   = 8'h9d;
   localparam logic [7:0] IDX_CH8_HIGH  = 8'h9e;
   localparam logic [7:0] IDX_CH8_LOW   = 8'h9f;
   localparam logic [7:0] IDX_BANK_SEL  = 8'hf0;
   localparam logic [7:0] IDX_LOCK_ONE  = 8'hf1;
   localparam logic [7:0] IDX_LOCK_TWO  = 8'hf2;
   localparam logic [7:0] IDX_CH_SELECT = 8'hf3;
   localparam logic [7:0] IDX_AUX_CTRL  = 8'he0;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int LOCK_CTRL_WORK_BIT = 5;
   localparam int LOCK_RAMP_WORK_BIT = 4;
   localparam int LOCK_CFG_BIT       = 3;
   localparam int LOCK_IRQ_MASK_BIT  = 2;
   localparam int LOCK_RAIL_WATCH_BIT = 1;
   localparam int LOCK_RAMP_ORDER_BIT = 0;
   localparam int AUX_SOFT_RST_BIT   = 0;
   localparam int AUX_SELFTEST_BIT   = 1;

   // ----------------------------------------------------------------
   // Values after reset and sequence codes.
   // ----------------------------------------------------------------
   localparam logic       BANK_RST      = 1'b0;
   localparam logic [5:0] LOCK_RST      = 6'h00;
   localparam logic [5:0] CH_SELECT_RST = 6'h3f;
   localparam logic       SELFTEST_RST  = 1'b0;
   localparam logic [15:0] STAMP_RST    = 16'h0000;
   localparam logic [1:0] SEQ_CODE_ON   = 2'h1;
   localparam logic [1:0] SEQ_CODE_OFF  = 2'h2;

   // ----------------------------------------------------------------
   // Timing: one timestamp tick is 50 us at a 100 ns clock.
   // ----------------------------------------------------------------
   localparam int         TICK_NS        = 50_000;
   localparam int         CLK_PERIOD_NS  = 100;
   localparam int         TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
   localparam logic [8:0] TICK_LAST      = 9'(TICK_CYCLES - 1);

   typedef enum logic [1:0] {RTW_SEQ_IDLE, RTW_SEQ_ON, RTW_SEQ_OFF} rtw_seq_state_t;

   // Word index taken from an APB byte address.
   function automatic logic [7:0] rtw_index(input logic [9:0] addr);
      return addr[9:2];
   endfunction

   // Places a byte in the low lane of a 32-bit read word.
   function automatic logic [31:0] rtw_byte(input logic [7:0] b);
      return {24'h00_0000, b};
   endfunction

endpackage

// *** bench/rtw_rail_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two supply rails that ramp one after the other during a sequence.
// ----------------------------------------------------------------
module rtw_rail_model
   import rtw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        go,
   input  wire logic [1:0]  code,
   input  wire logic [11:0] d7,
   input  wire logic [11:0] d8,
   output logic      [1:0]  uv_above,
   output logic      [1:0]  off_above
);
   logic [11:0] cnt_r;

   initial begin
      uv_above = 2'b00;
      off_above = 2'b00;
      cnt_r = 12'h000;
   end

   // An off sequence starts from live rails so that each one can fall later.
   // Each rail crosses once, at its own delay, counted from the start edge.
   always @(posedge pclk) begin
      cnt_r <= go ? 12'h000 : cnt_r + 12'h001;
      if (go) begin
         uv_above <= (code == SEQ_CODE_OFF) ? 2'b11 : 2'b00;
         off_above <= (code == SEQ_CODE_OFF) ? 2'b11 : 2'b00;
      end else begin
         if (cnt_r == d7) begin
            uv_above[0] <= (code == SEQ_CODE_ON);
            off_above[0] <= (code == SEQ_CODE_ON);
         end
         if (cnt_r == d8) begin
            uv_above[1] <= (code == SEQ_CODE_ON);
            off_above[1] <= (code == SEQ_CODE_ON);
         end
      end
   end
endmodule // rtw_rail_model

// *** bench/ramp_timestamp_write_lock_test.sv ***
`timescale 1ns/1ps
module ramp_timestamp_write_lock_test;
   import rtw_pkg::*;
   typedef struct {logic [31:0] d; logic e;} rtw_exp_t;
   logic        pclk, presetn, psel, penable, pwrite, st_done, go, pready, pslverr, bank_out;
   logic        soft_rst;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  pwr_code, slp_code, mcode, uv_above, off_above;
   logic [5:0]  gwb, cwb, rv;
   logic [11:0] d7, d8;
   int          n_mismatch, compares, n_pulse;
   rtw_exp_t    expq[$];

   rtw_ramp_lock i_rtw_ramp_lock (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_state_input(pwr_code),
      .sleep_state_input(slp_code), .undervolt_low_fine_above(uv_above),
      .off_level_above(off_above), .selftest_seq2_exit_done(st_done),
      .bank_select_out(bank_out), .group_write_block(gwb), .channel_watch_block(cwb),
      .supervisor_soft_reset(soft_rst));
   rtw_rail_model i_rtw_rail_model (.pclk(pclk), .go(go), .code(mcode), .d7(d7), .d8(d8),
      .uv_above(uv_above), .off_above(off_above));

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // The request stays put until pready is seen high at a rising edge.
   task automatic xfer(input logic [7:0] i, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A stalled slave is counted here; the run carries on to the verdict, which then fails.
      if (n >= 50) begin
         n_mismatch++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      xfer(i, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic er = 1'b0);
      expq.push_back('{e, er});
      xfer(i, 1'b0, 32'h0000_0000);
   endtask

   // Starts a sequence on one code input and reads both stamps once it is over.
   task automatic ramp(input logic slp, input logic [1:0] c, input int e7, input int e8);
      d7 <= 12'(250 + 500 * e7 + $urandom_range(99));
      d8 <= 12'(250 + 500 * e8 + $urandom_range(99));
      @(posedge pclk);
      go <= 1'b1;
      mcode <= c;
      if (slp) slp_code <= c;
      else pwr_code <= c;
      @(posedge pclk);
      go <= 1'b0;
      repeat (int'(d7 > d8 ? d7 : d8) + 300) @(posedge pclk);
      rd(IDX_CH7_HIGH, 32'h0000_0000);
      rd(IDX_CH7_LOW, 32'(e7));
      rd(IDX_CH8_HIGH, 32'h0000_0000);
      rd(IDX_CH8_LOW, 32'(e8));
   endtask

   // ----------------------------------------------------------------
   // Read results are taken at the edge that completes the access phase.
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && expq.size() > 0) begin
         chk("prdata", expq[0].d, prdata);
         chk("pslverr", {31'h0, expq[0].e}, {31'h0, pslverr});
         void'(expq.pop_front());
      end
      if (soft_rst === 1'b1) n_pulse++;
   end

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // A hung run is cut short here and counted as a failure.
   initial begin
      repeat (100000) @(posedge pclk);
      n_mismatch++;
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, st_done, go} = 6'h00;
      {paddr, pwdata, pwr_code, slp_code, mcode, d7, d8} = '0;
      n_mismatch = 0;
      compares = 0;
      n_pulse = 0;
      void'($urandom(3));
      rv = 6'($urandom);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_BANK_SEL, 32'h0000_0000);
      rd(IDX_LOCK_ONE, 32'h0000_0000);
      rd(IDX_LOCK_TWO, 32'h0000_0000);
      rd(IDX_CH_SELECT, 32'h0000_003f);
      wr(IDX_BANK_SEL, 32'h0000_00ff);
      rd(IDX_BANK_SEL, 32'h0000_0001);
      chk("bank_select_out", 32'h1, {31'h0, bank_out});
      rd(IDX_CH7_HIGH, 32'h0000_0000, 1'b1);
      wr(IDX_BANK_SEL, 32'h0000_0000);
      rd(8'h00, 32'h0000_0000, 1'b1);
      ramp(1'b0, SEQ_CODE_ON, 2, 4);
      ramp(1'b1, SEQ_CODE_OFF, 3, 1);
      ramp(1'b1, SEQ_CODE_ON, 1, 2);
      ramp(1'b0, SEQ_CODE_OFF, 4, 3);
      wr(IDX_CH7_LOW, 32'h0000_00aa);
      rd(IDX_CH7_LOW, 32'h0000_0004);
      wr(IDX_CH_SELECT, 32'(rv));
      wr(IDX_AUX_CTRL, 32'h0000_0002);
      for (int b = 0; b < 6; b++) begin
         wr(IDX_LOCK_ONE, 32'(1 << b));
         @(negedge pclk) chk("group_write_block", 32'((1 << b) - 1), 32'(gwb));
         wr(IDX_LOCK_TWO, 32'(1 << b));
         @(negedge pclk) chk("group_write_block", 32'((2 << b) - 1), 32'(gwb));
      end
      chk("channel_watch_block", 32'(rv), 32'(cwb));
      wr(IDX_LOCK_ONE, 32'h0000_00c0);
      rd(IDX_LOCK_ONE, 32'h0000_003f);
      wr(IDX_CH_SELECT, 32'(~rv));
      rd(IDX_CH_SELECT, 32'(rv));
      wr(IDX_AUX_CTRL, 32'h0000_0001);
      rd(IDX_AUX_CTRL, 32'h0000_0002);
      rd(IDX_LOCK_TWO, 32'h0000_003f);
      st_done <= 1'b1;
      repeat (4) @(posedge pclk);
      st_done <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(IDX_LOCK_ONE, 32'h0000_0000);
      rd(IDX_LOCK_TWO, 32'h0000_0000);
      wr(IDX_LOCK_ONE, 32'h0000_0001);
      wr(IDX_LOCK_TWO, 32'h0000_0001);
      rd(IDX_LOCK_TWO, 32'h0000_0001);
      wr(IDX_AUX_CTRL, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      rd(IDX_LOCK_TWO, 32'h0000_0000);
      chk("soft_reset_pulses", 32'h1, 32'(n_pulse));
      repeat (2) @(posedge pclk);
      chk("pending_reads", 32'h0, 32'(expq.size()));
      conclude();
   end
endmodule // ramp_timestamp_write_lock_test
